//--- design/dac_i2c_host.sv
/*
 host-side i2c master that writes channel data into the dac's serial port.
 assumes open-drain scl/sda with external pull-ups, resolved by the bench;
 the interface-select straps of the device are set by the board.
*/
// Summary of operation
// - sda only changes while scl is low, except start and stop
// - start is sda falling while scl is high
// - stop is sda rising while scl is high, ending the transaction
// - repeated start may replace stop; device accepts it directly
// - on a missing acknowledge the master reports failure for retry
// - direction bit of the address byte is always sent as 0
// - single mode: address, pointer, two data bytes, stop
// - without stop, another pointer and two bytes update a further channel
// - pointer ff starts burst at channel 0
// - lines are only pulled low or released, never driven high
// - serial mode with interface-select high, i2c with protocol-select low
`timescale 1ns/1ps
`include "dac_i2c_map.svh"

module dac_i2c_host
    import dac_i2c_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        REQ_VALID,
    input  wire logic [1:0]  REQ_MODE,
    input  wire logic        REQ_LAST,
    input  wire logic [5:0]  REQ_CHANNEL,
    input  wire logic [1:0]  REQ_REGSEL,
    input  wire logic [13:0] REQ_DATA,
    input  wire logic        ADDR_SEL_HI,
    input  wire logic        ADDR_SEL_LO,
    output logic             REQ_READY,
    output logic             DONE,
    output logic             NACK_ERR,
    output logic             BUSY,
    input  wire logic        SCL_I,
    output logic             SCL_O,
    output logic             SCL_OE,
    input  wire logic        SDA_I,
    output logic             SDA_O,
    output logic             SDA_OE
);
    phase_e              phase_q;
    byte_kind_e          kind_q;
    cmd_mode_e           mode_q;
    logic [`QTR_W-1:0]   tick_q;
    logic [1:0]          qtr_q;
    logic [3:0]          bit_q;
    logic [7:0]          shift_q;
    logic                scl_low_q;
    logic                sda_low_q;
    logic                ready_q;
    logic                done_q;
    logic                nack_q;
    logic                busy_q;
    logic                open_q;
    logic                last_q;
    logic [`CHAN_W-1:0]  chan_q;
    logic [`REGSEL_W-1:0] regsel_q;
    logic [`DATA_W-1:0]  data_q;
    logic [`CHAN_W-1:0]  burst_ch_q;
    logic                sda_s1_q;
    logic                sda_s2_q;

    // qtr_tick marks each quarter of an scl period
    wire qtr_tick  = (tick_q == `QTR_W'(`QTR_CYCLES - 1));
    // take on the registered ready the user sees, so no request is taken twice
    wire take      = REQ_VALID && REQ_READY;
    wire in_ack    = (bit_q == `ACK_BIT);
    wire byte_end  = qtr_tick && (qtr_q == 2'h3) && in_ack;
    wire ack_seen  = !sda_s2_q;
    wire burst_end = (burst_ch_q == `LAST_CHANNEL);

    function automatic logic [7:0] byte_for(input byte_kind_e k,
                                            input logic [5:0] ch,
                                            input cmd_mode_e m,
                                            input logic [1:0] rs,
                                            input logic [13:0] d,
                                            input logic a1,
                                            input logic a0);
        unique case (k)
            BY_ADDR: byte_for = {`ADDR_UPPER, a1, a0, `RW_WRITE};
            BY_PTR:  byte_for = (m == CMD_BURST) ? `BURST_PTR
                                                 : {2'h0, ch};
            BY_HI:   byte_for = {rs, d[13:8]};
            default: byte_for = d[7:0];
        endcase
    endfunction

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            sda_s1_q <= 1'h1;
            sda_s2_q <= 1'h1;
        end
        else
        begin
            sda_s1_q <= SDA_I;
            sda_s2_q <= sda_s1_q;
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            tick_q <= '0;
        else if (phase_q == ST_IDLE || phase_q == ST_DONE || qtr_tick)
            tick_q <= '0;
        else
            tick_q <= tick_q + `QTR_W'(1);
    end

    // next byte after an acknowledged byte
    wire byte_kind_e next_kind = byte_kind_e'(
        (kind_q == BY_ADDR) ? BY_PTR :
        (kind_q == BY_PTR)  ? BY_HI  :
        (kind_q == BY_HI)   ? BY_LO  : BY_PTR);
    wire byte_kind_e cont_kind = byte_kind_e'(
        (mode_q == CMD_BURST) ? BY_HI : BY_PTR);
    wire [`REGSEL_W-1:0] cont_rs = (mode_q == CMD_BURST) ? 2'h3 : REQ_REGSEL;

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            phase_q    <= ST_IDLE;
            kind_q     <= BY_ADDR;
            mode_q     <= CMD_SINGLE;
            qtr_q      <= 2'h0;
            bit_q      <= 4'h0;
            shift_q    <= 8'h0;
            scl_low_q  <= 1'h0;
            sda_low_q  <= 1'h0;
            ready_q    <= 1'h0;
            done_q     <= 1'h0;
            nack_q     <= 1'h0;
            busy_q     <= 1'h0;
            open_q     <= 1'h0;
            last_q     <= 1'h0;
            chan_q     <= '0;
            regsel_q   <= '0;
            data_q     <= '0;
            burst_ch_q <= '0;
        end
        else
        begin
            done_q <= 1'h0;
            unique case (phase_q)
                ST_IDLE:
                begin
                    ready_q <= !take;
                    if (take)
                    begin
                        mode_q   <= cmd_mode_e'(REQ_MODE);
                        last_q   <= REQ_LAST;
                        chan_q   <= REQ_CHANNEL;
                        regsel_q <= (cmd_mode_e'(REQ_MODE) == CMD_BURST)
                                    ? 2'h3 : REQ_REGSEL;
                        data_q   <= REQ_DATA;
                        busy_q   <= 1'h1;
                        nack_q   <= 1'h0;
                        qtr_q    <= 2'h0;
                        if (open_q)
                        begin
                            // continuation: skip address and start
                            kind_q  <= cont_kind;
                            shift_q <= byte_for(cont_kind, REQ_CHANNEL,
                                       mode_q, cont_rs, REQ_DATA,
                                       ADDR_SEL_HI, ADDR_SEL_LO);
                            bit_q   <= 4'h0;
                            phase_q <= ST_BIT;
                        end
                        else
                        begin
                            kind_q     <= BY_ADDR;
                            burst_ch_q <= '0;
                            shift_q    <= byte_for(BY_ADDR, REQ_CHANNEL,
                                          cmd_mode_e'(REQ_MODE), REQ_REGSEL,
                                          REQ_DATA, ADDR_SEL_HI,
                                          ADDR_SEL_LO);
                            phase_q    <= ST_START;
                        end
                    end
                end
                ST_START, ST_RSTART:
                begin
                    // sda falls while scl released high, then scl falls
                    if (qtr_tick)
                    begin
                        qtr_q <= qtr_q + 2'h1;
                        if (qtr_q == 2'h0)
                        begin
                            sda_low_q <= 1'h0;
                            scl_low_q <= 1'h0;
                        end
                        if (qtr_q == 2'h1)
                            sda_low_q <= 1'h1;
                        if (qtr_q == 2'h2)
                            scl_low_q <= 1'h1;
                        if (qtr_q == 2'h3)
                        begin
                            bit_q   <= 4'h0;
                            phase_q <= ST_BIT;
                        end
                    end
                end
                ST_BIT:
                begin
                    if (qtr_tick)
                    begin
                        qtr_q <= qtr_q + 2'h1;
                        if (qtr_q == 2'h0)
                            sda_low_q <= in_ack ? 1'h0 : !shift_q[7];
                        if (qtr_q == 2'h1)
                            scl_low_q <= 1'h0;
                        if (qtr_q == 2'h2 && in_ack && !ack_seen)
                            nack_q <= 1'h1;
                        if (qtr_q == 2'h3)
                        begin
                            scl_low_q <= 1'h1;
                            if (!in_ack)
                            begin
                                shift_q <= {shift_q[6:0], 1'h0};
                                bit_q   <= bit_q + 4'h1;
                            end
                        end
                    end
                    if (byte_end)
                    begin
                        qtr_q <= 2'h0;
                        bit_q <= 4'h0;
                        if (nack_q)
                            phase_q <= ST_STOP;
                        else if (kind_q == BY_LO)
                        begin
                            // the device commits the channel here
                            if (mode_q == CMD_BURST)
                                burst_ch_q <= burst_ch_q + `CHAN_W'(1);
                            if (mode_q == CMD_BURST && burst_end)
                                mode_q <= CMD_MULTI;
                            phase_q <= (last_q || mode_q == CMD_SINGLE)
                                       ? ST_STOP : ST_DONE;
                        end
                        else if (kind_q == BY_PTR && mode_q == CMD_BURST
                                 && !open_q)
                        begin
                            kind_q  <= BY_HI;
                            shift_q <= byte_for(BY_HI, chan_q, mode_q,
                                       regsel_q, data_q, 1'h0, 1'h0);
                        end
                        else
                        begin
                            kind_q  <= next_kind;
                            shift_q <= byte_for(next_kind, chan_q, mode_q,
                                       regsel_q, data_q, 1'h0, 1'h0);
                        end
                    end
                end
                ST_STOP:
                begin
                    if (qtr_tick)
                    begin
                        qtr_q <= qtr_q + 2'h1;
                        if (qtr_q == 2'h0)
                            sda_low_q <= 1'h1;
                        if (qtr_q == 2'h1)
                            scl_low_q <= 1'h0;
                        if (qtr_q == 2'h2)
                            sda_low_q <= 1'h0;
                        if (qtr_q == 2'h3)
                        begin
                            open_q  <= 1'h0;
                            phase_q <= ST_DONE;
                        end
                    end
                end
                default:
                begin
                    // ST_DONE: report, keep bus held if no stop was sent
                    if (phase_q == ST_DONE && busy_q)
                    begin
                        done_q  <= 1'h1;
                        busy_q  <= 1'h0;
                        open_q  <= !(last_q || mode_q == CMD_SINGLE
                                     || nack_q);
                        ready_q <= 1'h1;
                        phase_q <= ST_IDLE;
                    end
                    else
                    begin
                        ready_q <= 1'h1;
                        phase_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            REQ_READY <= 1'h0;
            DONE      <= 1'h0;
            NACK_ERR  <= 1'h0;
            BUSY      <= 1'h0;
            SCL_O     <= 1'h0;
            SCL_OE    <= 1'h0;
            SDA_O     <= 1'h0;
            SDA_OE    <= 1'h0;
        end
        else
        begin
            REQ_READY <= ready_q && !take;
            DONE      <= done_q;
            NACK_ERR  <= nack_q;
            BUSY      <= busy_q;
            SCL_O     <= 1'h0;
            SCL_OE    <= scl_low_q;
            SDA_O     <= 1'h0;
            SDA_OE    <= sda_low_q;
        end
    end
endmodule

//--- inc/dac_i2c_map.svh
/*
 constants for the host-side i2c write controller: slave address,
 pointer codes, byte layouts and bus timing counts.
 assumes a 100 MHz system clock.
*/
`ifndef DAC_I2C_MAP_SVH
`define DAC_I2C_MAP_SVH
`define CLK_PERIOD_NS    10
`define SCL_PERIOD_NS    2500
`define QTR_CYCLES       ((`SCL_PERIOD_NS / 4 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define QTR_W            8
`define ADDR_UPPER       5'h15
`define RW_WRITE         1'h0
`define BURST_PTR        8'hff
`define LAST_CHANNEL     6'h27
`define CHAN_W           6
`define DATA_W           14
`define REGSEL_W         2
`define BIT_CNT_LAST     4'h8
`define ACK_BIT          4'h8
`endif

//--- inc/dac_i2c_pkg.sv
/*
 types for the host-side i2c write controller.
 assumes dac_i2c_map.svh supplies the numeric constants.
*/
package dac_i2c_pkg;
    typedef enum logic [1:0]
    {
        CMD_SINGLE,
        CMD_MULTI,
        CMD_BURST
    } cmd_mode_e;

    typedef enum logic [3:0]
    {
        ST_IDLE,
        ST_START,
        ST_BIT,
        ST_STOP,
        ST_RSTART,
        ST_DONE
    } phase_e;

    typedef enum logic [2:0]
    {
        BY_ADDR,
        BY_PTR,
        BY_HI,
        BY_LO
    } byte_kind_e;
endpackage

//--- testbench/dac_dev_model.sv
/*
 behavioural model of the dac's i2c write port.
 assumes resolved scl/sda wires; ack only ever pulls sda low.
*/
`timescale 1ns/1ps
module dac_dev_model
(
    input  wire logic        scl,
    input  wire logic        sda,
    input  wire logic [1:0]  pins,
    output logic             ack_oe,
    output logic [21:0]      wr_word,
    output int               wr_cnt
);
    logic [7:0] sh;
    logic [7:0] hi;
    logic [5:0] ch;
    logic       on;
    logic       burst;
    int         bits;
    int         idx;
    initial
    begin
        {ack_oe, on, burst, sh, hi, ch, wr_word} = '0;
        bits = 0;
        idx = 0;
        wr_cnt = 0;
    end
    always @(negedge sda)
        if (scl === 1'b1)
        begin
            on = 1'b1;
            bits = 0;
            idx = 0;
            burst = 1'b0;
        end
    always @(posedge sda)
        if (scl === 1'b1)
        begin
            on = 1'b0;
            burst = 1'b0;
        end
    always @(posedge scl)
        if (on && bits < 8)
        begin
            sh = {sh[6:0], sda};
            bits++;
        end
    always @(negedge scl)
        if (on && bits == 9)
        begin
            ack_oe = 1'b0;
            bits = 0;
        end
        else if (on && bits == 8)
        begin
            bits = 9;
            ack_oe = 1'b1;
            case (idx)
                0: if (sh !== {5'h15, pins, 1'b0})
                begin
                    ack_oe = 1'b0;
                    on = 1'b0;
                end
                1:
                begin
                    burst = (sh == 8'hff);
                    ch = burst ? 6'h00 : sh[5:0];
                end
                2: hi = sh;
                default:
                begin
                    wr_word = {ch, hi, sh};
                    wr_cnt++;
                    if (burst)
                    begin
                        burst = (ch != 6'h27);
                        ch = ch + 6'h01;
                    end
                end
            endcase
            idx = (idx == 3) ? (burst ? 2 : 1) : idx + 1;
        end
endmodule

//--- testbench/dac_i2c_host_asserts.sv
/*
 protocol checker for the host-side i2c write controller.
 assumes scl/sda inputs carry the resolved open-drain wire levels.
*/
`timescale 1ns/1ps
module dac_i2c_host_asserts
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic REQ_VALID,
    input wire logic REQ_READY,
    input wire logic DONE,
    input wire logic NACK_ERR,
    input wire logic BUSY,
    input wire logic SCL_I,
    input wire logic SCL_O,
    input wire logic SCL_OE,
    input wire logic SDA_I,
    input wire logic SDA_O,
    input wire logic SDA_OE
);
    logic       scl_q;
    logic       sda_q;
    logic [3:0] bit_q;
    logic [3:0] bit_d;
    wire        scl_rise = SCL_I & ~scl_q;
    wire        start_w  = SCL_I & scl_q & sda_q & ~SDA_I;
    wire        stop_w   = SCL_I & scl_q & ~sda_q & SDA_I;
    // bit position 1..9 inside a byte, 0 after start or stop
    assign bit_d = (start_w | stop_w) ? 4'h0 : !scl_rise ? bit_q :
                   (bit_q == 4'h9) ? 4'h1 : bit_q + 4'h1;
    always_ff @(posedge CLK or posedge RST)
        if (RST)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            bit_q <= 4'h0;
        end
        else
        begin
            scl_q <= SCL_I;
            sda_q <= SDA_I;
            bit_q <= bit_d;
        end
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    sequence released_s;
        !SCL_OE [*8];
    endsequence
    sequence start_s;
        SDA_OE ##[1:300] SCL_OE;
    endsequence
    lines_low_a: assert property (!SCL_O && !SDA_O)
        else $error("open-drain output driven high");
    reset_quiet_a: assert property (disable iff (1'b0)
        RST |-> !SCL_OE && !SDA_OE && !BUSY && !DONE)
        else $error("lines or status active in reset");
    take_busy_a: assert property (REQ_VALID && REQ_READY
        |=> !REQ_READY ##1 BUSY) else $error("request not taken");
    done_pulse_a: assert property (DONE |=> !DONE)
        else $error("done longer than one cycle");
    data_stable_a: assert property ($fell(SDA_OE) && SCL_I
        && $past(SCL_I) |-> released_s) else $error("sda moved in scl high");
    start_pos_a: assert property ($rose(SDA_OE) && SCL_I
        && $past(SCL_I) |-> bit_q inside {4'h0, 4'h1})
        else $error("sda fell mid byte while scl high");
    start_seq_a: assert property (start_w |-> start_s)
        else $error("start not followed by clocking");
    ack_free_a: assert property (bit_q == 4'h9 && SCL_I && scl_q
        |-> !SDA_OE) else $error("master drove sda in ack slot");
    nack_flag_a: assert property (scl_rise && bit_q == 4'h8
        && SDA_I |-> ##[1:1000] NACK_ERR) else $error("missed nack");
    stop_end_a: assert property (stop_w |-> ##[0:300] DONE)
        else $error("stop without done");
endmodule
bind dac_i2c_host dac_i2c_host_asserts dac_i2c_host_asserts_i
(
    .CLK(CLK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
    .DONE(DONE), .NACK_ERR(NACK_ERR), .BUSY(BUSY), .SCL_I(SCL_I),
    .SCL_O(SCL_O), .SCL_OE(SCL_OE), .SDA_I(SDA_I), .SDA_O(SDA_O),
    .SDA_OE(SDA_OE)
);

//--- testbench/dac_i2c_slave_write_port_test.sv
/*
 self-checking bench for the host-side i2c write controller.
 assumes the dac model answers on the same open-drain wires.
*/
`timescale 1ns/1ps
`define CHK(g, w) begin checks_done++; if ((g) !== (w)) begin mismatches++; \
 $display("BAD %0t got %h want %h", $time, g, w); end end
module dac_i2c_slave_write_port_test;
    logic        CLK = 1'b0;
    logic        RST;
    logic        REQ_VALID = 1'b0;
    logic [1:0]  REQ_MODE = 2'h0;
    logic        REQ_LAST = 1'b0;
    logic [5:0]  REQ_CHANNEL = 6'h00;
    logic [1:0]  REQ_REGSEL = 2'h0;
    logic [13:0] REQ_DATA = 14'h0000;
    logic        ADDR_SEL_HI = 1'b0;
    logic        ADDR_SEL_LO = 1'b0;
    logic [1:0]  dev_pins = 2'h1;
    logic        REQ_READY, DONE, NACK_ERR, BUSY, SCL_O, SCL_OE, SDA_O;
    logic        SDA_OE, ack_oe;
    logic [21:0] wr_word, want;
    logic [21:0] exp_q[$];
    int          mismatches = 0;
    int          checks_done = 0;
    int          wr_cnt;
    int          bch;
    wire         scl_w = SCL_OE ? 1'b0 : 1'b1;
    wire         sda_w = (SDA_OE || ack_oe) ? 1'b0 : 1'b1;
    always #5 CLK = ~CLK;
    dac_i2c_host dac_i2c_host_i (.CLK(CLK), .RST(RST), .REQ_VALID(REQ_VALID),
        .REQ_MODE(REQ_MODE), .REQ_LAST(REQ_LAST), .REQ_CHANNEL(REQ_CHANNEL),
        .REQ_REGSEL(REQ_REGSEL), .REQ_DATA(REQ_DATA), .ADDR_SEL_HI(ADDR_SEL_HI),
        .ADDR_SEL_LO(ADDR_SEL_LO), .REQ_READY(REQ_READY), .DONE(DONE),
        .NACK_ERR(NACK_ERR), .BUSY(BUSY), .SCL_I(scl_w), .SCL_O(SCL_O),
        .SCL_OE(SCL_OE), .SDA_I(sda_w), .SDA_O(SDA_O), .SDA_OE(SDA_OE));
    dac_dev_model dac_dev_model_i (.scl(scl_w), .sda(sda_w), .pins(dev_pins),
        .ack_oe(ack_oe), .wr_word(wr_word), .wr_cnt(wr_cnt));
    always @(wr_cnt)
    begin
        want = exp_q.size() ? exp_q.pop_front() : 'x;
        `CHK(wr_word, want)
    end
    task automatic req(input logic [1:0] m, input logic l, input logic [5:0] c,
                       input logic [1:0] r, input logic nk);
        int n;
        logic [13:0] d;
        n = 0;
        d = 14'($urandom);
        // burst ignores channel and regsel: device counts, regsel forced
        if (!nk)
            exp_q.push_back({(m == 2'h2) ? bch[5:0] : c,
                             (m == 2'h2) ? 2'h3 : r, d});
        if (m == 2'h2)
            bch++;
        REQ_VALID <= 1'b1;
        REQ_MODE <= m;
        REQ_LAST <= l;
        REQ_CHANNEL <= c;
        REQ_REGSEL <= r;
        REQ_DATA <= d;
        do @(posedge CLK); while (REQ_READY !== 1'b1);
        REQ_VALID <= 1'b0;
        do
        begin
            @(posedge CLK);
            n++;
        end
        while (DONE !== 1'b1 && n < 40000);
        if (n >= 40000)
            mismatches++;
        `CHK(NACK_ERR, nk)
        `CHK(BUSY, 1'b0)
    endtask
    task print_verdict;
        if (mismatches == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        #950000;
        mismatches++;
        print_verdict();
    end
    initial
    begin
        // an edge on reset at time zero clears the flops before the first clock
        RST <= 1'b1;
        void'($urandom(32'hbab7));
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        req(2'h0, 1'b1, 6'h05, 2'h2, 1'b1);
        for (int a = 0; a < 4; a++)
        begin
            dev_pins <= 2'(a);
            ADDR_SEL_HI <= a[1];
            ADDR_SEL_LO <= a[0];
            @(posedge CLK);
            req(2'h0, 1'b1, 6'($urandom % 40), 2'($urandom), 1'b0);
        end
        req(2'h1, 1'b0, 6'h27, 2'h1, 1'b0);
        req(2'h1, 1'b1, 6'h00, 2'($urandom), 1'b0);
        bch = 0;
        for (int i = 0; i < 3; i++)
            req(2'h2, i == 2, 6'h11, 2'h0, 1'b0);
        `CHK(exp_q.size(), 0)
        print_verdict();
    end
endmodule
